// ---- hdl/amtr_defines.svh ----
`ifndef AMTR_DEFINES_SVH
`define AMTR_DEFINES_SVH
`define AMTR_ADDR_W 12
`define AMTR_ADDR_FAULT_STATUS 12'h2C1
`define AMTR_ADDR_ALARM_SUPPRESS 12'h2C2
`define AMTR_ADDR_A_DUAL_TIME 12'h310
`define AMTR_ADDR_B_DUAL_TIME 12'h313
`define AMTR_ADDR_A_IL_INA_TIME 12'h314
`define AMTR_ADDR_B_IL_INA_TIME 12'h315
`define AMTR_ADDR_A_IL_INB_TIME 12'h31A
`define AMTR_ADDR_B_IL_INB_TIME 12'h31B
`define AMTR_ADDR_A_ZP_INA_OFFSET 12'h344
`define AMTR_ADDR_OPER_MODE 12'h3F0
`define AMTR_SUPPRESS_RESET 8'h05
`define AMTR_STATUS_RESET 8'h05
`define AMTR_BIT_DIVIDER 0
`define AMTR_BIT_REALIGN 2
`define AMTR_OFFSET_W 12
`define AMTR_NUM_TIME_TRIMS 6
`define AMTR_OPER_MODE_W 2
`endif

// ---- hdl/amtr_fault_bit.sv ----
`timescale 1ns/100ps
`default_nettype none
module amtr_fault_bit (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Set and clear.
  input wire logic set_event,
  input wire logic clear_req,
  // Flag.
  output logic flag
);
  // Set beats clear so an event in the clearing cycle is not lost.
  always_ff @(posedge clk) begin
    if (rst) begin
      flag <= 1'b1;
    end else if (set_event) begin
      flag <= 1'b1;
    end else if (clear_req) begin
      flag <= 1'b0;
    end
  end
endmodule : amtr_fault_bit
`default_nettype wire

// ---- hdl/amtr_pkg.sv ----
package amtr_pkg;
  typedef enum logic [1:0] {
    AMTR_MODE_DUAL,
    AMTR_MODE_INTERLEAVE_FG,
    AMTR_MODE_INTERLEAVE_BG,
    AMTR_MODE_SINGLE_OTHER
  } amtr_mode_e;
  typedef logic [7:0] amtr_byte_t;
endpackage : amtr_pkg

// ---- hdl/amtr_regs.sv ----
// Overview of operation
// - Suppress bit 2 set keeps the phase-realign alarm out of the alarm flag.
// - Suppress bit 0 set keeps the divider-mismatch alarm out of the alarm flag.
// - Each timing trim is an 8-bit field setting one core's sampling instant.
// - Applied timing trim is chosen by core and operating mode.
// - Timing trims load their defaults from the fuse store at initialisation.
// - Software reads back and overwrites trims; written value then applies.
// - Dual mode: 0x310 drives core A, 0x313 drives core B.
// - Interleaved foreground mode: trim chosen by core and selected input.
// - Offset trim 0x344 applies to core A on input A, 0 degree, foreground.
// - Alarm flag high when any status bit is set and not suppressed.
// - Divider disagreement sets divider alarm; writing 1 clears it.
// - After reset every alarm status bit reads 1.
`timescale 1ns/100ps
`default_nettype none
`include "amtr_defines.svh"
module amtr_regs (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Register port.
  input wire logic [`AMTR_ADDR_W-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Fuse store.
  input wire logic fuse_load,
  input wire logic [7:0] fuse_a_dual_time,
  input wire logic [7:0] fuse_b_dual_time,
  input wire logic [7:0] fuse_a_il_ina_time,
  input wire logic [7:0] fuse_b_il_ina_time,
  input wire logic [7:0] fuse_a_il_inb_time,
  input wire logic [7:0] fuse_b_il_inb_time,
  input wire logic [15:0] fuse_a_zp_ina_offset,
  // Alarm sources.
  input wire logic divider_mismatch_in,
  input wire logic phase_realign_in,
  // Input select pin, 0 selects input A.
  input wire logic input_select_pin,
  // Alarm and trims.
  output logic alarm_flag,
  output logic [7:0] core_a_time_trim,
  output logic [7:0] core_b_time_trim,
  output logic [`AMTR_OFFSET_W-1:0] core_a_offset_trim,
  output logic core_a_offset_trim_en,
  output logic [8*`AMTR_NUM_TIME_TRIMS-1:0] time_trim_vec,
  output logic [15:0] offset_trim_vec
);
  logic [7:0] tt_q [`AMTR_NUM_TIME_TRIMS];
  logic [7:0] tt_fuse [`AMTR_NUM_TIME_TRIMS];
  logic [`AMTR_ADDR_W-1:0] tt_addr [`AMTR_NUM_TIME_TRIMS];
  logic [15:0] offset_q;
  logic [7:0] suppress;
  logic [`AMTR_OPER_MODE_W-1:0] oper_mode;
  logic [7:0] status;
  logic [1:0] div_sync;
  logic [1:0] realign_sync;
  logic [1:0] insel_sync;
  logic status_wr;
  logic [15:0] next_rdata;
  logic next_alarm;
  logic [7:0] next_a_time;
  logic [7:0] next_b_time;
  logic next_offset_en;
  logic is_dual_mode;
  logic is_fg_mode;

  assign tt_fuse[0] = fuse_a_dual_time;
  assign tt_fuse[1] = fuse_b_dual_time;
  assign tt_fuse[2] = fuse_a_il_ina_time;
  assign tt_fuse[3] = fuse_b_il_ina_time;
  assign tt_fuse[4] = fuse_a_il_inb_time;
  assign tt_fuse[5] = fuse_b_il_inb_time;
  assign tt_addr[0] = `AMTR_ADDR_A_DUAL_TIME;
  assign tt_addr[1] = `AMTR_ADDR_B_DUAL_TIME;
  assign tt_addr[2] = `AMTR_ADDR_A_IL_INA_TIME;
  assign tt_addr[3] = `AMTR_ADDR_B_IL_INA_TIME;
  assign tt_addr[4] = `AMTR_ADDR_A_IL_INB_TIME;
  assign tt_addr[5] = `AMTR_ADDR_B_IL_INB_TIME;

  // Pins and analog flags are outside the clock domain.
  always_ff @(posedge clk) begin
    if (rst) begin
      div_sync <= 2'h0;
      realign_sync <= 2'h0;
      insel_sync <= 2'h0;
    end else begin
      div_sync <= {div_sync[0], divider_mismatch_in};
      realign_sync <= {realign_sync[0], phase_realign_in};
      insel_sync <= {insel_sync[0], input_select_pin};
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `AMTR_NUM_TIME_TRIMS; gi++) begin : g_tt
      amtr_trim_reg #(.WIDTH(8)) u_tt (
        .clk(clk),
        .rst(rst),
        .load(fuse_load),
        .fuse_value(tt_fuse[gi]),
        .wr(reg_wr && reg_addr == tt_addr[gi]),
        .wr_value(reg_wdata[7:0]),
        .value(tt_q[gi])
      );
    end
  endgenerate

  // Reserved upper bits are kept as written.
  amtr_trim_reg #(.WIDTH(16)) u_offset (
    .clk(clk),
    .rst(rst),
    .load(fuse_load),
    .fuse_value(fuse_a_zp_ina_offset),
    .wr(reg_wr && reg_addr == `AMTR_ADDR_A_ZP_INA_OFFSET),
    .wr_value(reg_wdata),
    .value(offset_q)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      suppress <= `AMTR_SUPPRESS_RESET;
    end else if (reg_wr && reg_addr == `AMTR_ADDR_ALARM_SUPPRESS) begin
      suppress <= reg_wdata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      oper_mode <= `AMTR_OPER_MODE_W'(amtr_pkg::AMTR_MODE_DUAL);
    end else if (reg_wr && reg_addr == `AMTR_ADDR_OPER_MODE) begin
      oper_mode <= reg_wdata[`AMTR_OPER_MODE_W-1:0];
    end
  end

  assign status_wr = reg_wr && reg_addr == `AMTR_ADDR_FAULT_STATUS;

  // Mode decodes, read only by the checks at the end of the module.
  assign is_dual_mode = oper_mode == `AMTR_OPER_MODE_W'(amtr_pkg::AMTR_MODE_DUAL);
  assign is_fg_mode = oper_mode == `AMTR_OPER_MODE_W'(amtr_pkg::AMTR_MODE_INTERLEAVE_FG);

  amtr_fault_bit u_div_alarm (
    .clk(clk),
    .rst(rst),
    .set_event(div_sync[1]),
    .clear_req(status_wr && reg_wdata[`AMTR_BIT_DIVIDER]),
    .flag(status[`AMTR_BIT_DIVIDER])
  );

  amtr_fault_bit u_realign_alarm (
    .clk(clk),
    .rst(rst),
    .set_event(realign_sync[1]),
    .clear_req(status_wr && reg_wdata[`AMTR_BIT_REALIGN]),
    .flag(status[`AMTR_BIT_REALIGN])
  );

  assign status[1] = 1'b0;
  assign status[7:3] = 5'h00;

  always_comb begin
    next_alarm = |(status & ~suppress);
  end

  // Trim selection by core, mode and input.
  always_comb begin
    next_a_time = tt_q[0];
    next_b_time = tt_q[1];
    next_offset_en = 1'b0;
    case (amtr_pkg::amtr_mode_e'(oper_mode))
      amtr_pkg::AMTR_MODE_DUAL: begin
        next_a_time = tt_q[0];
        next_b_time = tt_q[1];
      end
      amtr_pkg::AMTR_MODE_INTERLEAVE_FG: begin
        next_a_time = insel_sync[1] ? tt_q[4] : tt_q[2];
        next_b_time = insel_sync[1] ? tt_q[5] : tt_q[3];
        next_offset_en = !insel_sync[1];
      end
      default: begin
        next_a_time = tt_q[0];
        next_b_time = tt_q[1];
      end
    endcase
  end

  always_comb begin
    next_rdata = 16'h0000;
    case (reg_addr)
      `AMTR_ADDR_FAULT_STATUS: next_rdata = {8'h00, status};
      `AMTR_ADDR_ALARM_SUPPRESS: next_rdata = {8'h00, suppress};
      `AMTR_ADDR_A_DUAL_TIME: next_rdata = {8'h00, tt_q[0]};
      `AMTR_ADDR_B_DUAL_TIME: next_rdata = {8'h00, tt_q[1]};
      `AMTR_ADDR_A_IL_INA_TIME: next_rdata = {8'h00, tt_q[2]};
      `AMTR_ADDR_B_IL_INA_TIME: next_rdata = {8'h00, tt_q[3]};
      `AMTR_ADDR_A_IL_INB_TIME: next_rdata = {8'h00, tt_q[4]};
      `AMTR_ADDR_B_IL_INB_TIME: next_rdata = {8'h00, tt_q[5]};
      `AMTR_ADDR_A_ZP_INA_OFFSET: next_rdata = offset_q;
      `AMTR_ADDR_OPER_MODE: next_rdata = {14'h0000, oper_mode};
      default: next_rdata = 16'h0000;
    endcase
  end

  // Read data is held only in the cycle after the strobe.
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      alarm_flag <= 1'b0;
      core_a_time_trim <= 8'h00;
      core_b_time_trim <= 8'h00;
      core_a_offset_trim <= 12'h000;
      core_a_offset_trim_en <= 1'b0;
    end else begin
      alarm_flag <= next_alarm;
      core_a_time_trim <= next_a_time;
      core_b_time_trim <= next_b_time;
      core_a_offset_trim <= offset_q[`AMTR_OFFSET_W-1:0];
      core_a_offset_trim_en <= next_offset_en;
    end
  end

  // Per-register outputs lag the stored value by one cycle so they come from a flop.
  always_ff @(posedge clk) begin
    if (rst) begin
      time_trim_vec <= '0;
      offset_trim_vec <= 16'h0000;
    end else begin
      for (int i = 0; i < `AMTR_NUM_TIME_TRIMS; i++) begin
        time_trim_vec[8*i +: 8] <= tt_q[i];
      end
      offset_trim_vec <= offset_q;
    end
  end

  realign_masked_a: assert property (@(posedge clk) disable iff (rst)
    (suppress[`AMTR_BIT_REALIGN] && !status[`AMTR_BIT_DIVIDER]) |=> !alarm_flag)
    else $error("realign alarm leaked through suppress");
  divider_masked_a: assert property (@(posedge clk) disable iff (rst)
    (suppress[`AMTR_BIT_DIVIDER] && !status[`AMTR_BIT_REALIGN]) |=> !alarm_flag)
    else $error("divider alarm leaked through suppress");
  alarm_flag_a: assert property (@(posedge clk) disable iff (rst)
    alarm_flag == $past(|(status & suppress ^ status)))
    else $error("alarm flag mismatch");
  realign_set_a: assert property (@(posedge clk) disable iff (rst)
    realign_sync[1] |=> status[`AMTR_BIT_REALIGN])
    else $error("realign alarm not set");
  divider_set_a: assert property (@(posedge clk) disable iff (rst)
    div_sync[1] |=> status[`AMTR_BIT_DIVIDER])
    else $error("divider alarm not set");
  divider_clear_a: assert property (@(posedge clk) disable iff (rst)
    (status_wr && reg_wdata[`AMTR_BIT_DIVIDER] && !div_sync[1]) |=> !status[`AMTR_BIT_DIVIDER])
    else $error("divider alarm not cleared");
  reset_status_a: assert property (@(posedge clk)
    rst |=> (status[`AMTR_BIT_DIVIDER] && status[`AMTR_BIT_REALIGN]))
    else $error("status not set after reset");
  suppress_reset_a: assert property (@(posedge clk)
    rst |=> suppress == `AMTR_SUPPRESS_RESET)
    else $error("suppress register not at reset value");
  fuse_offset_a: assert property (@(posedge clk) disable iff (rst)
    fuse_load |=> offset_q == $past(fuse_a_zp_ina_offset))
    else $error("offset fuse value not loaded");
  trim_hold_a: assert property (@(posedge clk) disable iff (rst)
    (!fuse_load && !(reg_wr && reg_addr == `AMTR_ADDR_A_DUAL_TIME)) |=> $stable(tt_q[0]))
    else $error("trim changed without a write");
  rdata_idle_a: assert property (@(posedge clk) disable iff (rst)
    !reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data outside its cycle");
  dual_a_select_a: assert property (@(posedge clk) disable iff (rst)
    is_dual_mode |=> core_a_time_trim == $past(tt_q[0]))
    else $error("dual mode core A trim wrong");
  il_ina_select_a: assert property (@(posedge clk) disable iff (rst)
    (is_fg_mode && !insel_sync[1]) |=> core_a_time_trim == $past(tt_q[2]))
    else $error("interleave input A core A trim wrong");
  il_inb_select_a: assert property (@(posedge clk) disable iff (rst)
    (is_fg_mode && insel_sync[1]) |=> core_b_time_trim == $past(tt_q[5]))
    else $error("interleave input B core B trim wrong");
  offset_apply_a: assert property (@(posedge clk) disable iff (rst)
    (is_fg_mode && !insel_sync[1]) |=> core_a_offset_trim_en)
    else $error("offset trim not applied");
  offset_copy_a: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> offset_trim_vec == $past(offset_q))
    else $error("offset trim output stale");
  fuse_load_a: assert property (@(posedge clk) disable iff (rst)
    fuse_load |=> tt_q[0] == $past(fuse_a_dual_time))
    else $error("fuse value not loaded");
  trim_write_a: assert property (@(posedge clk) disable iff (rst)
    (reg_wr && !fuse_load && reg_addr == `AMTR_ADDR_B_DUAL_TIME)
    |=> ##1 time_trim_vec[15:8] == $past(reg_wdata[7:0], 2))
    else $error("written trim not presented");
  dual_select_a: assert property (@(posedge clk) disable iff (rst)
    is_dual_mode |=> core_b_time_trim == $past(tt_q[1]))
    else $error("dual mode core B trim wrong");
  offset_en_a: assert property (@(posedge clk) disable iff (rst)
    !is_fg_mode |=> !core_a_offset_trim_en)
    else $error("offset trim enabled outside foreground input A");
endmodule : amtr_regs
`default_nettype wire

// ---- hdl/amtr_trim_reg.sv ----
`timescale 1ns/100ps
`default_nettype none
module amtr_trim_reg #(
  parameter int WIDTH = 8
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Fuse load.
  input wire logic load,
  input wire logic [WIDTH-1:0] fuse_value,
  // Software write.
  input wire logic wr,
  input wire logic [WIDTH-1:0] wr_value,
  // Stored value.
  output logic [WIDTH-1:0] value
);
  // A fuse load takes priority because it only happens during initialisation.
  always_ff @(posedge clk) begin
    if (rst) begin
      value <= '0;
    end else if (load) begin
      value <= fuse_value;
    end else if (wr) begin
      value <= wr_value;
    end
  end
endmodule : amtr_trim_reg
`default_nettype wire

// ---- test/amtr_regs_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "amtr_defines.svh"
module amtr_regs_bench;
  logic clk, rst, reg_wr, reg_rd, fuse_load, div_in, realign_in, in_sel, alarm_flag, off_en;
  logic [11:0] reg_addr, off_trim;
  logic [15:0] reg_wdata, reg_rdata, off_vec, f_off;
  logic [7:0] f [6];
  logic [7:0] trim_a, trim_b;
  logic [47:0] tt_vec;
  int fails, compares, cycles;
  localparam logic [11:0] ADDRS [6] = '{`AMTR_ADDR_A_DUAL_TIME, `AMTR_ADDR_B_DUAL_TIME,
    `AMTR_ADDR_A_IL_INA_TIME, `AMTR_ADDR_B_IL_INA_TIME, `AMTR_ADDR_A_IL_INB_TIME,
    `AMTR_ADDR_B_IL_INB_TIME};

  amtr_regs DUT (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fuse_load(fuse_load),
    .fuse_a_dual_time(f[0]), .fuse_b_dual_time(f[1]), .fuse_a_il_ina_time(f[2]),
    .fuse_b_il_ina_time(f[3]), .fuse_a_il_inb_time(f[4]), .fuse_b_il_inb_time(f[5]),
    .fuse_a_zp_ina_offset(f_off), .divider_mismatch_in(div_in),
    .phase_realign_in(realign_in), .input_select_pin(in_sel), .alarm_flag(alarm_flag),
    .core_a_time_trim(trim_a), .core_b_time_trim(trim_b), .core_a_offset_trim(off_trim),
    .core_a_offset_trim_en(off_en), .time_trim_vec(tt_vec), .offset_trim_vec(off_vec)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      stop_test();
    end
  end

  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  // Waits n edges and lets that edge's updates land before sampling.
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  task automatic wr_reg(input logic [11:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input logic [11:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check(48'(reg_rdata), 48'(e));
  endtask : rd_chk

  task automatic t_reset();
    rd_chk(`AMTR_ADDR_ALARM_SUPPRESS, 16'h0005);
    rd_chk(`AMTR_ADDR_FAULT_STATUS, 16'h0005);
    check(48'(alarm_flag), 48'h0);
    rd_chk(12'h300, 16'h0000);
  endtask : t_reset

  task automatic t_fuse();
    @(posedge clk);
    fuse_load <= 1'b1;
    @(posedge clk);
    fuse_load <= 1'b0;
    settle(2);
    check(tt_vec, {f[5], f[4], f[3], f[2], f[1], f[0]});
    check(48'(off_vec), 48'(f_off));
    check(48'({trim_a, trim_b}), 48'({f[0], f[1]}));
    for (int i = 0; i < 6; i++) begin
      rd_chk(ADDRS[i], 16'(f[i]));
    end
    rd_chk(`AMTR_ADDR_A_ZP_INA_OFFSET, f_off);
  endtask : t_fuse

  task automatic t_overwrite();
    wr_reg(`AMTR_ADDR_A_DUAL_TIME, 16'h005A);
    settle(2);
    check(48'(trim_a), 48'h5A);
    check(48'(tt_vec[7:0]), 48'h5A);
    wr_reg(`AMTR_ADDR_B_DUAL_TIME, 16'h00A5);
    settle(2);
    check(48'(tt_vec[15:8]), 48'hA5);
    check(48'(trim_b), 48'hA5);
    rd_chk(`AMTR_ADDR_A_DUAL_TIME, 16'h005A);
    wr_reg(`AMTR_ADDR_A_ZP_INA_OFFSET, 16'hF123);
    rd_chk(`AMTR_ADDR_A_ZP_INA_OFFSET, 16'hF123);
    check(48'(off_vec), 48'hF123);
  endtask : t_overwrite

  task automatic mode_chk(input logic [1:0] m, input logic s, input logic [7:0] ea,
                          input logic [7:0] eb, input logic en);
    wr_reg(`AMTR_ADDR_OPER_MODE, 16'(m));
    in_sel <= s;
    settle(5);
    check(48'({trim_a, trim_b, off_en}), 48'({ea, eb, en}));
  endtask : mode_chk

  task automatic t_modes();
    mode_chk(2'd1, 1'b0, f[2], f[3], 1'b1);
    check(48'(off_trim), 48'h123);
    mode_chk(2'd1, 1'b1, f[4], f[5], 1'b0);
    mode_chk(2'd2, 1'b0, 8'h5A, 8'hA5, 1'b0);
    mode_chk(2'd3, 1'b0, 8'h5A, 8'hA5, 1'b0);
    mode_chk(2'd0, 1'b0, 8'h5A, 8'hA5, 1'b0);
  endtask : t_modes

  task automatic t_alarm();
    wr_reg(`AMTR_ADDR_ALARM_SUPPRESS, 16'h0000);
    settle(2);
    check(48'(alarm_flag), 48'h1);
    wr_reg(`AMTR_ADDR_FAULT_STATUS, 16'h0005);
    settle(2);
    check(48'(alarm_flag), 48'h0);
    rd_chk(`AMTR_ADDR_FAULT_STATUS, 16'h0000);
    div_in <= 1'b1;
    settle(3);
    div_in <= 1'b0;
    settle(4);
    rd_chk(`AMTR_ADDR_FAULT_STATUS, 16'h0001);
    check(48'(alarm_flag), 48'h1);
    // Reserved bits set alongside the mask must not change the flag.
    wr_reg(`AMTR_ADDR_ALARM_SUPPRESS, 16'h00FB);
    settle(2);
    check(48'(alarm_flag), 48'h0);
    rd_chk(`AMTR_ADDR_ALARM_SUPPRESS, 16'h00FB);
    wr_reg(`AMTR_ADDR_FAULT_STATUS, 16'h0001);
    // Realign suppress must be set before the realign event to test it.
    wr_reg(`AMTR_ADDR_ALARM_SUPPRESS, 16'h00FF);
    realign_in <= 1'b1;
    settle(3);
    realign_in <= 1'b0;
    settle(4);
    check(48'(alarm_flag), 48'h0);
    wr_reg(`AMTR_ADDR_ALARM_SUPPRESS, 16'h00FA);
    settle(2);
    check(48'(alarm_flag), 48'h1);
  endtask : t_alarm

  initial begin
    fails = 0;
    compares = 0;
    cycles = 0;
    rst = 1'b1;
    {reg_wr, reg_rd, fuse_load, div_in, realign_in, in_sel} = '0;
    reg_addr = '0;
    reg_wdata = '0;
    f = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66};
    f_off = 16'hA987;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    settle(1);
    t_reset();
    t_fuse();
    t_overwrite();
    t_modes();
    t_alarm();
    stop_test();
  end
endmodule : amtr_regs_bench
`default_nettype wire
